// File: rtl/pfp_pkg.sv
// Package of constants and types for the pixel format packer
package pfp_pkg;
  localparam int PIX_W       = 12;
  localparam int BYTE_W      = 8;
  localparam int FIFO_DEPTH  = 4;
  localparam logic [7:0] CHROMA_ZERO = 8'h00;
  localparam logic [2:0] FMT_RESET   = 3'h0;
  // Output formats
  typedef enum logic [2:0] {
    PFP_FMT_MONO8  = 3'h0,
    PFP_FMT_PACK12 = 3'h1,
    PFP_FMT_UYVY   = 3'h2,
    PFP_FMT_YUYV   = 3'h3,
    PFP_FMT_RAWGB  = 3'h4
  } pfp_fmt_e;
  // Emitter states
  typedef enum logic [4:0] {
    PFP_ST_IDLE = 5'h01,
    PFP_ST_B0   = 5'h02,
    PFP_ST_B1   = 5'h04,
    PFP_ST_B2   = 5'h08,
    PFP_ST_B3   = 5'h10
  } pfp_state_e;
endpackage : pfp_pkg

// File: rtl/pfp_fifo.sv
// Small byte FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module pfp_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             nrst_i,
  // Write side
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  input  wire logic [WIDTH-1:0] wr_data_i,
  // Read side
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i,
  output logic [WIDTH-1:0]      rd_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign wr_ready_o = (cnt_r != (AW+1)'(DEPTH));
  assign rd_valid_o = (cnt_r != '0);
  assign push       = wr_valid_i && wr_ready_o;
  assign pop        = rd_valid_o && rd_ready_i;
  assign rd_data_o  = mem_r[rp_r];

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_r[wp_r] <= wr_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // pfp_fifo
`default_nettype wire

// File: rtl/pfp_packer.sv
// Pixel format packer: sensor pixels in, formatted byte stream out
`timescale 1ns/100ps
`default_nettype none
module pfp_packer #(
  parameter int PIX_W      = pfp_pkg::PIX_W,
  parameter int FIFO_DEPTH = pfp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             nrst_i,
  // Format selection
  input  wire logic [2:0]       fmt_sel_i,
  output logic [2:0]            fmt_active_o,
  // Pixel input stream
  input  wire logic             pix_valid_i,
  output logic                  pix_ready_o,
  input  wire logic [PIX_W-1:0] pix_data_i,
  input  wire logic             pix_sof_i,
  input  wire logic             pix_sol_i,
  input  wire logic             pix_eol_i,
  // Byte output stream
  output logic                  byte_valid_o,
  input  wire logic             byte_ready_i,
  output logic [7:0]            byte_data_o,
  output logic                  byte_sof_o,
  output logic                  byte_eol_o,
  // Bayer site of the sample in flight (0 G, 1 B, 2 R)
  output logic [1:0]            raw_site_o
);
  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  pfp_pkg::pfp_state_e st_r;
  logic [2:0]          fmt_r;
  logic [PIX_W-1:0]    even_r;
  logic [PIX_W-1:0]    odd_r;
  logic                sof_r;
  logic                eol_r;
  logic                line_odd_r;
  logic                col_odd_r;
  logic [1:0]          site_r;
  logic                take;
  logic                fifo_rdy;
  logic                pushv;
  logic [7:0]          pushd;
  logic                push_sof;
  logic                push_eol;
  logic [2:0]          fmt_now;
  logic [7:0]          y_even;
  logic [7:0]          y_odd;
  logic                pair_cmplt;
  logic                one_byte;

  //////////////////////////////////////////////////////////////////////////////
  // Input acceptance: only in idle, or when holding the even pixel of a pair
  assign pix_ready_o = (st_r == pfp_pkg::PFP_ST_IDLE);
  assign take        = pix_valid_i && pix_ready_o;
  assign fmt_now     = (take && pix_sof_i) ? fmt_sel_i : fmt_r;
  assign y_even      = even_r[PIX_W-1 -: 8];
  assign y_odd       = odd_r[PIX_W-1 -: 8];
  // Paired formats wait for the odd pixel unless the line ends early
  assign pair_cmplt  = col_odd_r;
  // One-byte formats keep every pixel in the even slot
  assign one_byte    = (fmt_now == pfp_pkg::PFP_FMT_MONO8) ||
                       (fmt_now == pfp_pkg::PFP_FMT_RAWGB);

  //////////////////////////////////////////////////////////////////////////////
  // Active format latched at frame start
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fmt_r <= pfp_pkg::FMT_RESET;
    end else if (take && pix_sof_i) begin
      fmt_r <= fmt_sel_i;
    end
  end
  assign fmt_active_o = fmt_r;

  //////////////////////////////////////////////////////////////////////////////
  // Line and column parity, Bayer site tracking
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_odd_r <= 1'b0;
      col_odd_r  <= 1'b0;
      site_r     <= 2'h0;
    end else if (take) begin
      if (pix_sof_i) begin
        line_odd_r <= 1'b0;
        col_odd_r  <= 1'b1;
        site_r     <= 2'h0;
      end else if (pix_sol_i) begin
        line_odd_r <= ~line_odd_r;
        col_odd_r  <= 1'b1;
        site_r     <= line_odd_r ? 2'h0 : 2'h2;
      end else begin
        col_odd_r  <= ~col_odd_r;
        if (line_odd_r) begin
          site_r <= col_odd_r ? 2'h0 : 2'h2;
        end else begin
          site_r <= col_odd_r ? 2'h1 : 2'h0;
        end
      end
    end
  end
  assign raw_site_o = site_r;

  //////////////////////////////////////////////////////////////////////////////
  // Pixel capture
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      even_r <= '0;
      odd_r  <= '0;
      sof_r  <= 1'b0;
      eol_r  <= 1'b0;
    end else if (take) begin
      if (!col_odd_r || pix_sof_i || pix_sol_i || one_byte) begin
        even_r <= pix_data_i;
        odd_r  <= '0;
        sof_r  <= pix_sof_i;
      end else begin
        odd_r  <= pix_data_i;
      end
      eol_r <= pix_eol_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Byte emitter
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= pfp_pkg::PFP_ST_IDLE;
    end else begin
      unique case (st_r)
        pfp_pkg::PFP_ST_IDLE: begin
          if (take) begin
            unique case (fmt_now)
              pfp_pkg::PFP_FMT_MONO8, pfp_pkg::PFP_FMT_RAWGB: begin
                st_r <= pfp_pkg::PFP_ST_B0;
              end
              default: begin
                // Even pixel of a pair waits for the odd one
                if ((pair_cmplt && !pix_sof_i && !pix_sol_i) || pix_eol_i) begin
                  st_r <= pfp_pkg::PFP_ST_B0;
                end
              end
            endcase
          end
        end
        pfp_pkg::PFP_ST_B0: begin
          if (fifo_rdy) begin
            if (fmt_r == pfp_pkg::PFP_FMT_MONO8 || fmt_r == pfp_pkg::PFP_FMT_RAWGB) begin
              st_r <= pfp_pkg::PFP_ST_IDLE;
            end else begin
              st_r <= pfp_pkg::PFP_ST_B1;
            end
          end
        end
        pfp_pkg::PFP_ST_B1: begin
          if (fifo_rdy) begin
            st_r <= pfp_pkg::PFP_ST_B2;
          end
        end
        pfp_pkg::PFP_ST_B2: begin
          if (fifo_rdy) begin
            st_r <= (fmt_r == pfp_pkg::PFP_FMT_PACK12) ? pfp_pkg::PFP_ST_IDLE
                                                      : pfp_pkg::PFP_ST_B3;
          end
        end
        pfp_pkg::PFP_ST_B3: begin
          if (fifo_rdy) begin
            st_r <= pfp_pkg::PFP_ST_IDLE;
          end
        end
        default: st_r <= pfp_pkg::PFP_ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Byte selection per state and format
  always_comb begin
    pushv    = (st_r != pfp_pkg::PFP_ST_IDLE);
    pushd    = 8'h00;
    push_sof = 1'b0;
    push_eol = 1'b0;
    unique case (st_r)
      pfp_pkg::PFP_ST_B0: begin
        push_sof = sof_r;
        unique case (fmt_r)
          pfp_pkg::PFP_FMT_PACK12: pushd = even_r[11:4];
          pfp_pkg::PFP_FMT_UYVY:   pushd = pfp_pkg::CHROMA_ZERO;
          pfp_pkg::PFP_FMT_YUYV:   pushd = y_even;
          default:                 pushd = even_r[PIX_W-1 -: 8];
        endcase
        if (fmt_r == pfp_pkg::PFP_FMT_MONO8 || fmt_r == pfp_pkg::PFP_FMT_RAWGB) begin
          push_eol = eol_r;
        end
      end
      pfp_pkg::PFP_ST_B1: begin
        unique case (fmt_r)
          pfp_pkg::PFP_FMT_PACK12: pushd = {odd_r[3:0], even_r[3:0]};
          pfp_pkg::PFP_FMT_UYVY:   pushd = y_even;
          default:                 pushd = pfp_pkg::CHROMA_ZERO;
        endcase
      end
      pfp_pkg::PFP_ST_B2: begin
        unique case (fmt_r)
          pfp_pkg::PFP_FMT_PACK12: pushd = odd_r[11:4];
          pfp_pkg::PFP_FMT_UYVY:   pushd = pfp_pkg::CHROMA_ZERO;
          default:                 pushd = y_odd;
        endcase
        push_eol = eol_r && (fmt_r == pfp_pkg::PFP_FMT_PACK12);
      end
      pfp_pkg::PFP_ST_B3: begin
        pushd    = (fmt_r == pfp_pkg::PFP_FMT_UYVY) ? y_odd : pfp_pkg::CHROMA_ZERO;
        push_eol = eol_r;
      end
      default: begin
        pushv = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output buffer
  pfp_fifo #(
    .WIDTH (10),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i  (ref_clk_i),
    .nrst_i     (nrst_i),
    .wr_valid_i (pushv),
    .wr_ready_o (fifo_rdy),
    .wr_data_i  ({push_sof, push_eol, pushd}),
    .rd_valid_o (byte_valid_o),
    .rd_ready_i (byte_ready_i),
    .rd_data_o  ({byte_sof_o, byte_eol_o, byte_data_o})
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_PACK_B0: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (st_r == pfp_pkg::PFP_ST_B0 && fmt_r == pfp_pkg::PFP_FMT_PACK12) |-> pushd == even_r[11:4])
    else $error("packed first byte wrong");
  AST_PACK_B1: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (st_r == pfp_pkg::PFP_ST_B1 && fmt_r == pfp_pkg::PFP_FMT_PACK12)
      |-> pushd == {odd_r[3:0], even_r[3:0]})
    else $error("packed middle byte wrong");
  AST_PACK_B2: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (st_r == pfp_pkg::PFP_ST_B2 && fmt_r == pfp_pkg::PFP_FMT_PACK12) |-> pushd == odd_r[11:4])
    else $error("packed third byte wrong");
  AST_PACK_THREE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (st_r == pfp_pkg::PFP_ST_B2 && fifo_rdy && fmt_r == pfp_pkg::PFP_FMT_PACK12)
      |=> st_r == pfp_pkg::PFP_ST_IDLE)
    else $error("packed group not three bytes");
  AST_CHROMA_ZERO: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (fmt_r == pfp_pkg::PFP_FMT_YUYV && (st_r == pfp_pkg::PFP_ST_B1 || st_r == pfp_pkg::PFP_ST_B3))
      |-> pushd == 8'h00)
    else $error("chroma not zero");
  AST_LUMA: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (fmt_r == pfp_pkg::PFP_FMT_UYVY && st_r == pfp_pkg::PFP_ST_B1) |-> pushd == y_even)
    else $error("luma not brightness");
  AST_RAW_BYTE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (take && fmt_now == pfp_pkg::PFP_FMT_RAWGB)
      |=> st_r == pfp_pkg::PFP_ST_B0 && pushd == $past(pix_data_i[PIX_W-1 -: 8]))
    else $error("raw byte not sensor value");
  AST_FMT_HOLD: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !(take && pix_sof_i) |=> fmt_r == $past(fmt_r))
    else $error("format changed mid frame");
  AST_SITE_ODD: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (take && pix_sol_i && !pix_sof_i && !line_odd_r) |=> site_r == 2'h2)
    else $error("odd line not red first");

  //////////////////////////////////////////////////////////////////////////////
  // Group length tracking for the checks
  logic [2:0] grp_cnt_r;
  logic       grp_end;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      grp_cnt_r <= 3'h0;
    end else if (st_r == pfp_pkg::PFP_ST_IDLE) begin
      grp_cnt_r <= 3'h0;
    end else if (pushv && fifo_rdy) begin
      grp_cnt_r <= grp_cnt_r + 3'h1;
    end
  end
  // First idle cycle after a group: count must match the format
  assign grp_end = (st_r == pfp_pkg::PFP_ST_IDLE) && (grp_cnt_r != 3'h0);

  AST_GROUP_PACK: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (grp_end && fmt_r == pfp_pkg::PFP_FMT_PACK12)
      |-> grp_cnt_r == 3'h3)
    else $error("packed group length wrong");
  AST_GROUP_422: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (grp_end && (fmt_r == pfp_pkg::PFP_FMT_UYVY || fmt_r == pfp_pkg::PFP_FMT_YUYV))
      |-> grp_cnt_r == 3'h4)
    else $error("subsampled group length wrong");
  AST_GROUP_ONE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (grp_end && (fmt_r == pfp_pkg::PFP_FMT_MONO8 || fmt_r == pfp_pkg::PFP_FMT_RAWGB))
      |-> grp_cnt_r == 3'h1)
    else $error("one byte format group length wrong");
  AST_SITE_SOF: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (take && pix_sof_i) |=> site_r == 2'h0 && !line_odd_r)
    else $error("frame not green first");
  AST_SITE_EVEN: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (take && !pix_sof_i && !pix_sol_i && !line_odd_r)
      |=> site_r == (($past(site_r) == 2'h0) ? 2'h1 : 2'h0))
    else $error("even line not green blue");
  AST_SITE_ODDLN: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (take && !pix_sof_i && !pix_sol_i && line_odd_r)
      |=> site_r == (($past(site_r) == 2'h2) ? 2'h0 : 2'h2))
    else $error("odd line not red green");
  AST_CHROMA_UYVY: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (fmt_r == pfp_pkg::PFP_FMT_UYVY && (st_r == pfp_pkg::PFP_ST_B0 || st_r == pfp_pkg::PFP_ST_B2))
      |-> pushd == 8'h00)
    else $error("chroma not zero");
  AST_MONO_BYTE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (take && fmt_now == pfp_pkg::PFP_FMT_MONO8)
      |=> st_r == pfp_pkg::PFP_ST_B0 && pushd == $past(pix_data_i[PIX_W-1 -: 8]))
    else $error("mono byte not brightness");
  AST_BYTE_HOLD: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (byte_valid_o && !byte_ready_i) |=> byte_valid_o && $stable(byte_data_o))
    else $error("output byte not held");
  COV_PACK:  cover property (@(posedge ref_clk_i) fmt_r == pfp_pkg::PFP_FMT_PACK12
    && st_r == pfp_pkg::PFP_ST_B2 && fifo_rdy);
  COV_UYVY:  cover property (@(posedge ref_clk_i) fmt_r == pfp_pkg::PFP_FMT_UYVY
    && st_r == pfp_pkg::PFP_ST_B3 && fifo_rdy);
  COV_RAW:   cover property (@(posedge ref_clk_i) site_r == 2'h2 && take);
  COV_FULL:  cover property (@(posedge ref_clk_i) pushv && !fifo_rdy);
  COV_YUYV:  cover property (@(posedge ref_clk_i) fmt_r == pfp_pkg::PFP_FMT_YUYV
    && st_r == pfp_pkg::PFP_ST_B3 && fifo_rdy);
endmodule // pfp_packer
`default_nettype wire

// File: tb/pfp_host_model.sv
// Host side model: accepts formatted bytes, with optional back-pressure
`timescale 1ns/100ps
`default_nettype none
module pfp_host_model (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       nrst_i,
  // Stall mode: 0 always ready, 1 random stalls, 2 never ready
  input  wire logic [1:0] mode_i,
  // Byte stream from the packer
  input  wire logic       byte_valid_i,
  output logic            byte_ready_o,
  input  wire logic [7:0] byte_data_i,
  input  wire logic       byte_sof_i,
  input  wire logic       byte_eol_i,
  // Report of each byte taken: sof, eol, data
  output logic            got_o,
  output logic [9:0]      got_word_o
);
  integer seed = 32'h1C0FFEE7;

  initial byte_ready_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Ready changes only off the sampling edge
  always @(negedge ref_clk_i) begin
    byte_ready_o <= (mode_i == 2'h0) || (mode_i == 2'h1 && ($random(seed) % 3) != 0);
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      got_o      <= 1'b0;
      got_word_o <= 10'h000;
    end else begin
      got_o      <= byte_valid_i && byte_ready_o;
      got_word_o <= {byte_sof_i, byte_eol_i, byte_data_i};
    end
  end
endmodule // pfp_host_model
`default_nettype wire

// File: tb/pixel_format_packer_bench.sv
// Self-checking bench for the pixel format packer
`timescale 1ns/100ps
`default_nettype none
module pixel_format_packer_bench;
  logic        ref_clk_i = 1'b0;
  logic        nrst_i;
  logic [2:0]  fmt_sel_i;
  logic [2:0]  fmt_active_o;
  logic        pix_valid_i;
  logic        pix_ready_o;
  logic [11:0] pix_data_i;
  logic        pix_sof_i;
  logic        pix_sol_i;
  logic        pix_eol_i;
  logic        byte_valid_o;
  logic        byte_ready;
  logic [7:0]  byte_data_o;
  logic        byte_sof_o;
  logic        byte_eol_o;
  logic [1:0]  raw_site_o;
  logic [1:0]  host_mode;
  logic        got;
  logic [9:0]  got_word;
  logic [10:0] mon_w;
  logic [10:0] exp_q[$];
  integer      seed = 32'hfe7f02e6;
  int          miscompares = 0;
  int          tests_run = 0;
  int          cycles = 0;

  always #25 ref_clk_i = ~ref_clk_i;

  pfp_packer #(.PIX_W(12), .FIFO_DEPTH(4)) i_dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .fmt_sel_i(fmt_sel_i),
    .fmt_active_o(fmt_active_o), .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o),
    .pix_data_i(pix_data_i), .pix_sof_i(pix_sof_i), .pix_sol_i(pix_sol_i),
    .pix_eol_i(pix_eol_i), .byte_valid_o(byte_valid_o), .byte_ready_i(byte_ready),
    .byte_data_o(byte_data_o), .byte_sof_o(byte_sof_o), .byte_eol_o(byte_eol_o),
    .raw_site_o(raw_site_o));

  pfp_host_model i_host (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .mode_i(host_mode),
    .byte_valid_i(byte_valid_o), .byte_ready_o(byte_ready), .byte_data_i(byte_data_o),
    .byte_sof_i(byte_sof_o), .byte_eol_i(byte_eol_o), .got_o(got), .got_word_o(got_word));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_sig(input string n, input logic [2:0] e, input logic [2:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [2:0] site(input int l, input int c);
    if (l % 2 == 1) return (c % 2 == 1) ? 3'h0 : 3'h2;
    return (c % 2 == 1) ? 3'h1 : 3'h0;
  endfunction

  // Expected bytes of one pixel pair; flag bit 10 set where sof/eol are checked
  task automatic put_pair(input logic [2:0] f, input logic [11:0] a, input logic [11:0] b,
                          input logic s, input logic e);
    if (f == pfp_pkg::PFP_FMT_PACK12) begin
      exp_q.push_back({1'b1, s, 1'b0, a[11:4]});
      exp_q.push_back({1'b1, 2'h0, b[3:0], a[3:0]});
      exp_q.push_back({1'b1, 1'b0, e, b[11:4]});
    end else if (f == pfp_pkg::PFP_FMT_UYVY) begin
      exp_q.push_back({3'h0, 8'h00});
      exp_q.push_back({3'h0, a[11:4]});
      exp_q.push_back({3'h0, 8'h00});
      exp_q.push_back({3'h0, b[11:4]});
    end else begin
      exp_q.push_back({3'h0, a[11:4]});
      exp_q.push_back({3'h0, 8'h00});
      exp_q.push_back({3'h0, b[11:4]});
      exp_q.push_back({3'h0, 8'h00});
    end
  endtask

  // Leaves valid high between pixels so no signal is driven twice in a step
  task automatic send_pix(input logic [11:0] d, input logic s, input logic l, input logic e);
    int n;
    n = 0;
    pix_data_i  = d;
    pix_sof_i   = s;
    pix_sol_i   = l;
    pix_eol_i   = e;
    pix_valid_i = 1'b1;
    while (pix_ready_o !== 1'b1 && n < 500) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n == 500) chk_sig("pix_accept", 3'h1, {2'h0, pix_ready_o});
    @(negedge ref_clk_i);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 300) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n == 300) chk_sig("drain", 3'h0, 3'h1);
  endtask

  task automatic send_frame(input logic [2:0] fmt, input int nl, input bit blk);
    logic [11:0] d;
    logic [11:0] p0;
    logic        s;
    logic        e;
    logic        s0;
    int          np;
    host_mode = blk ? 2'h2 : {1'b0, 1'($random(seed))};
    fmt_sel_i = fmt;
    for (int l = 0; l < nl; l++) begin
      np = blk ? 8 : 1 + ($unsigned($random(seed)) % 7);
      for (int c = 0; c < np; c++) begin
        d = 12'($random(seed));
        if (l == 0 && c < 2) d = c ? 12'h000 : 12'hFFF;
        s = (l == 0 && c == 0);
        e = (c == np - 1);
        send_pix(d, s, c == 0, e);
        if (s) fmt_sel_i = 3'($random(seed));
        if (fmt == pfp_pkg::PFP_FMT_RAWGB) begin
          chk_sig("raw_site", site(l, c), {1'b0, raw_site_o});
        end
        if (c % 2 == 0) begin
          p0 = d;
          s0 = s;
        end
        if (fmt == pfp_pkg::PFP_FMT_MONO8 || fmt == pfp_pkg::PFP_FMT_RAWGB) begin
          exp_q.push_back({1'b1, s, e, d[11:4]});
        end else if (c % 2 == 1 || e) begin
          put_pair(fmt, p0, (c % 2 == 1) ? d : 12'h000, s0, e);
        end
        if (blk && c == 4) begin
          pix_valid_i = 1'b0;
          repeat (6) @(negedge ref_clk_i);
          chk_sig("pix_ready_full", 3'h0, {2'h0, pix_ready_o});
          host_mode = 2'h0;
        end
      end
    end
    pix_valid_i = 1'b0;
    @(negedge ref_clk_i);
    chk_sig("fmt_active", fmt, fmt_active_o);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge ref_clk_i) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk_sig("extra_byte", 3'h0, 3'h1);
      end else begin
        mon_w = exp_q.pop_front();
        chk_byte("byte_data", mon_w[7:0],
                 got_word[7:0]);
        if (mon_w[10]) chk_sig("byte_flags", {1'b0, mon_w[9:8]}, {1'b0, got_word[9:8]});
      end
    end
  end

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    nrst_i      = 1'b0;
    fmt_sel_i   = 3'h0;
    pix_valid_i = 1'b0;
    pix_data_i  = 12'h000;
    pix_sof_i   = 1'b0;
    pix_sol_i   = 1'b0;
    pix_eol_i   = 1'b0;
    host_mode   = 2'h0;
    repeat (4) @(negedge ref_clk_i);
    chk_sig("reset_state", 3'h1, {fmt_active_o[1:0] | {byte_valid_o, 1'b0}, pix_ready_o});
    chk_sig("reset_site", 3'h0, {1'b0, raw_site_o});
    nrst_i = 1'b1;
    @(negedge ref_clk_i);
    for (int f = 0; f < 5; f++) send_frame(3'(f), 3, 1'b0);
    for (int k = 0; k < 8; k++) send_frame(3'($unsigned($random(seed)) % 5), 2, 1'b0);
    host_mode = 2'h0;
    drain();
    send_frame(pfp_pkg::PFP_FMT_RAWGB, 1, 1'b1);
    drain();
    repeat (4) @(negedge ref_clk_i);
    chk_sig("bytes_missing", 3'h0, {2'h0, exp_q.size() != 0});
    summarize();
  end
endmodule // pixel_format_packer_bench
`default_nettype wire
